// >>> core/fpbp_defines.svh
// Constants for the flash program sequencer and block protection
`ifndef FPBP_DEFINES_SVH
`define FPBP_DEFINES_SVH
// Control bit positions in the flash control byte
`define FPBP_CTL_PGM_BIT 0
`define FPBP_CTL_ERASE_BIT 1
`define FPBP_CTL_MASS_BIT 2
`define FPBP_CTL_HIGH_VOLTAGE_ENABLE_BIT 3
// Boundary values of special meaning
`define FPBP_BOUND_OPEN 8'hFF
`define FPBP_BOUND_OPEN_ALT 8'hFE
`define FPBP_BOUND_ALL 8'h00
`define FPBP_BOUND_FACTORY 8'hFF
// Address forming of the protection start
`define FPBP_TOP_BITS 2'h3
`define FPBP_LOW_BITS 6'h00
`define FPBP_ADDR_TOP 16'hFFFF
// Array window and the non-array hole at the top
`define FPBP_ARRAY_BASE 16'hC000
`define FPBP_HOLE_LO 16'hFFD4
`define FPBP_HOLE_HI 16'hFFDF
// Address of the boundary byte inside the array
`define FPBP_BOUND_ADDR 16'hFF7E
// Page size mask (64-byte rows)
`define FPBP_PAGE_MASK 16'hFFC0
// Timing in ns and the clock period in ns
`define FPBP_CLK_NS 4
`define FPBP_NVH_NS 5000
`define FPBP_RCV_NS 1000
`define FPBP_NVH_CYC ((`FPBP_NVH_NS + `FPBP_CLK_NS - 1) / `FPBP_CLK_NS)
`define FPBP_RCV_CYC ((`FPBP_RCV_NS + `FPBP_CLK_NS - 1) / `FPBP_CLK_NS)
`endif

// >>> core/fpbp_pkg.sv
// Types for the flash program sequencer and block protection
package fpbp_pkg;
  typedef enum logic [2:0] {
    FPBP_IDLE = 3'h0,
    FPBP_ARMED = 3'h1,
    FPBP_HIGHV = 3'h3,
    FPBP_HOLD = 3'h2,
    FPBP_RECOVER = 3'h6
  } fpbp_state_e;
endpackage

// >>> core/fpbp_guard.sv
// Protection decision from the boundary byte
`timescale 1ns/1ns
`include "fpbp_defines.svh"
module fpbp_guard
  import fpbp_pkg::*;
(
  input wire logic [7:0] boundary_in,
  input wire logic [15:0] addr_in,
  input wire logic mass_in,
  input wire logic bypass_in,
  output logic refuse_out,
  output logic [15:0] start_out
);
  logic [15:0] start;
  logic locked;
  logic in_range;
  // Start address: top bits forced high, row bits low
  assign start = {`FPBP_TOP_BITS, boundary_in, `FPBP_LOW_BITS};
  assign start_out = start;
  // Any value but FF or FE also locks the boundary byte itself
  assign locked = (boundary_in != `FPBP_BOUND_OPEN) &&
                  (boundary_in != `FPBP_BOUND_OPEN_ALT);
  // All ones opens the array; all zeros gives start C000, whole array
  assign in_range = (boundary_in != `FPBP_BOUND_OPEN) &&
                    (addr_in >= start);
  // Test voltage bypasses every check
  always_comb begin
    refuse_out = 1'b0;
    if (!bypass_in) begin
      if (in_range) begin
        refuse_out = 1'b1;
      end
      if (locked && ((addr_in & `FPBP_PAGE_MASK) ==
                     (`FPBP_BOUND_ADDR & `FPBP_PAGE_MASK))) begin
        refuse_out = 1'b1;
      end
      if (mass_in && (boundary_in != `FPBP_BOUND_OPEN)) begin
        refuse_out = 1'b1;
      end
    end
  end
endmodule // fpbp_guard

// >>> core/fpbp_top.sv
// Flash program/erase sequencer with block protection
//
// Operation
// - Steps in order; unrelated accesses tolerated
// - Refuse high voltage inside protected region
// - Zero protects all; all ones protects none
// - Non FF/FE value locks boundary byte too
// - Boundary not FF disables mass erase
// - Test voltage bypasses all protection
// - Unprotected boundary page erases like others
// - Only array programming or erase changes the boundary
// - Start is 11, boundary bits, six zeros
// - Reset keeps boundary; factory value all ones
`timescale 1ns/1ns
`include "fpbp_defines.svh"
module fpbp_top
  import fpbp_pkg::*;
#(
  parameter int NVH_CYC = `FPBP_NVH_CYC,
  parameter int RCV_CYC = `FPBP_RCV_CYC
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  // Control byte writes from the CPU
  input wire logic CTL_WR_IN,
  input wire logic [7:0] CTL_DATA_IN,
  // Array write strobe (latches row and data during programming)
  input wire logic ARR_WR_IN,
  input wire logic [15:0] ARR_ADDR_IN,
  input wire logic [7:0] ARR_DATA_IN,
  // Boundary byte read strobe
  input wire logic BOUND_RD_IN,
  // Test high voltage present on the interrupt pin
  input wire logic TEST_HV_IN,
  // Status and array control
  output logic [7:0] CTL_OUT,
  output logic [7:0] BOUND_OUT,
  output logic HV_ON_OUT,
  output logic REFUSED_OUT,
  output logic READY_OUT,
  output logic BOUND_WR_OUT
);
  typedef struct packed {
    fpbp_state_e state;
    logic program_arm_bit;
    logic erase;
    logic mass;
    logic high_voltage_enable;
    logic bound_seen;
    logic [15:0] row;
    logic [15:0] cnt;
    logic refused;
    logic bound_wr;
  } fpbp_regs_s;

  fpbp_regs_s r_reg;
  fpbp_regs_s r_next;
  // Boundary byte: array content, not cleared by reset
  logic [7:0] bound_reg = `FPBP_BOUND_FACTORY;
  logic [7:0] bound_next;
  logic refuse;
  logic [15:0] start;
  logic want_hv;
  logic in_array;

  // ****************************************************************
  // Protection check
  // ****************************************************************
  fpbp_guard u_guard (
    .boundary_in(bound_reg),
    .addr_in(r_reg.row),
    .mass_in(r_reg.mass),
    .bypass_in(TEST_HV_IN),
    .refuse_out(refuse),
    .start_out(start)
  );

  // Array address check; the top hole is not array
  function automatic logic is_array(input logic [15:0] a);
    is_array = (a >= `FPBP_ARRAY_BASE) &&
               !((a >= `FPBP_HOLE_LO) && (a <= `FPBP_HOLE_HI));
  endfunction

  assign want_hv = CTL_WR_IN && CTL_DATA_IN[`FPBP_CTL_HIGH_VOLTAGE_ENABLE_BIT];
  assign in_array = is_array(ARR_ADDR_IN);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    r_next = r_reg;
    r_next.refused = 1'b0;
    r_next.bound_wr = 1'b0;
    bound_next = bound_reg;
    if (r_reg.cnt != 16'h0000) begin
      r_next.cnt = r_reg.cnt - 16'h0001;
    end
    // Other accesses do not disturb the step order
    case (r_reg.state)
      FPBP_IDLE: begin
        if (CTL_WR_IN) begin
          r_next.program_arm_bit = CTL_DATA_IN[`FPBP_CTL_PGM_BIT];
          r_next.erase = CTL_DATA_IN[`FPBP_CTL_ERASE_BIT];
          r_next.mass = CTL_DATA_IN[`FPBP_CTL_MASS_BIT];
          r_next.bound_seen = 1'b0;
          if (CTL_DATA_IN[`FPBP_CTL_PGM_BIT] ||
              CTL_DATA_IN[`FPBP_CTL_ERASE_BIT]) begin
            r_next.state = FPBP_ARMED;
          end
        end
      end
      FPBP_ARMED: begin
        // Row select latched from every array write inside the array window; the last one wins
        if (ARR_WR_IN && in_array) begin
          r_next.row = ARR_ADDR_IN;
        end
        if (want_hv) begin
          if (refuse) begin
            r_next.refused = 1'b1;
          end else begin
            r_next.high_voltage_enable = 1'b1;
            r_next.state = FPBP_HIGHV;
          end
        end else if (CTL_WR_IN) begin
          r_next.program_arm_bit = CTL_DATA_IN[`FPBP_CTL_PGM_BIT];
          r_next.erase = CTL_DATA_IN[`FPBP_CTL_ERASE_BIT];
          if (!CTL_DATA_IN[`FPBP_CTL_PGM_BIT] &&
              !CTL_DATA_IN[`FPBP_CTL_ERASE_BIT]) begin
            r_next.state = FPBP_IDLE;
            r_next.mass = 1'b0; // No stale mass after an abort
          end
        end
      end
      FPBP_HIGHV: begin
        // Byte programming; with the erase below, the boundary changes only in this state
        if (ARR_WR_IN && r_reg.program_arm_bit && in_array) begin
          r_next.row = ARR_ADDR_IN;
          // Checked row must be the boundary page, or a lock leaks
          if (ARR_ADDR_IN == `FPBP_BOUND_ADDR && !refuse &&
              ((r_reg.row & `FPBP_PAGE_MASK) ==
               (`FPBP_BOUND_ADDR & `FPBP_PAGE_MASK))) begin
            bound_next = bound_reg & ARR_DATA_IN;
            r_next.bound_wr = 1'b1;
          end
        end
        // Erase of an unprotected boundary page clears it
        if (r_reg.erase && !refuse &&
            (r_reg.mass || ((r_reg.row & `FPBP_PAGE_MASK) ==
             (`FPBP_BOUND_ADDR & `FPBP_PAGE_MASK)))) begin
          bound_next = `FPBP_BOUND_FACTORY;
        end
        if (CTL_WR_IN && !CTL_DATA_IN[`FPBP_CTL_PGM_BIT] &&
            !CTL_DATA_IN[`FPBP_CTL_ERASE_BIT]) begin
          r_next.program_arm_bit = 1'b0;
          r_next.erase = 1'b0;
          r_next.cnt = 16'(NVH_CYC);
          r_next.state = FPBP_HOLD;
        end
      end
      FPBP_HOLD: begin
        // High voltage may drop only after the hold time
        if (CTL_WR_IN && !CTL_DATA_IN[`FPBP_CTL_HIGH_VOLTAGE_ENABLE_BIT] &&
            r_reg.cnt == 16'h0000) begin
          r_next.high_voltage_enable = 1'b0;
          r_next.mass = 1'b0;
          r_next.cnt = 16'(RCV_CYC);
          r_next.state = FPBP_RECOVER;
        end
      end
      FPBP_RECOVER: begin
        if (r_reg.cnt == 16'h0000) begin
          r_next.state = FPBP_IDLE;
        end
      end
      default: begin
        r_next.state = FPBP_IDLE;
      end
    endcase
    // Read seen after the arm write; a read in the same cycle counts
    if (BOUND_RD_IN) begin
      r_next.bound_seen = 1'b1;
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Boundary lives in the array, so reset leaves it alone
  always_ff @(posedge CLOCK_IN) begin
    bound_reg <= bound_next;
  end

  // Outputs registered straight from next state
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      CTL_OUT <= 8'h00;
      BOUND_OUT <= `FPBP_BOUND_FACTORY;
      HV_ON_OUT <= 1'b0;
      REFUSED_OUT <= 1'b0;
      READY_OUT <= 1'b0;
      BOUND_WR_OUT <= 1'b0;
    end else begin
      CTL_OUT <= {4'h0, r_next.high_voltage_enable, r_next.mass, r_next.erase,
                  r_next.program_arm_bit};
      BOUND_OUT <= bound_next;
      HV_ON_OUT <= r_next.high_voltage_enable;
      REFUSED_OUT <= r_next.refused;
      READY_OUT <= (r_next.state == FPBP_IDLE);
      BOUND_WR_OUT <= r_next.bound_wr;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_refuse_hv;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      (r_reg.state == FPBP_ARMED && want_hv && refuse) |=>
      (!r_reg.high_voltage_enable && r_reg.state == FPBP_ARMED);
  endproperty
  a_refuse_hv: assert property (p_refuse_hv)
    else $error("High voltage set in protected region");

  property p_zero_all;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      (bound_reg == `FPBP_BOUND_ALL && !TEST_HV_IN &&
       r_reg.row >= `FPBP_ARRAY_BASE) |-> refuse;
  endproperty
  a_zero_all: assert property (p_zero_all)
    else $error("Zero boundary left array open");

  property p_ones_open;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      (bound_reg == `FPBP_BOUND_OPEN) |-> !refuse;
  endproperty
  a_ones_open: assert property (p_ones_open)
    else $error("Open boundary refused");

  property p_mass_off;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      (r_reg.mass && bound_reg != `FPBP_BOUND_OPEN && !TEST_HV_IN)
      |-> refuse;
  endproperty
  a_mass_off: assert property (p_mass_off)
    else $error("Mass erase allowed while protected");

  property p_bypass;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      TEST_HV_IN |-> !refuse;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Protection not bypassed under test voltage");

  property p_start;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      start == {2'b11, bound_reg, 6'b000000};
  endproperty
  a_start: assert property (p_start)
    else $error("Protection start address malformed");

  property p_bound_stable;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      (r_reg.state != FPBP_HIGHV) |=> $stable(bound_reg);
  endproperty
  a_bound_stable: assert property (p_bound_stable)
    else $error("Boundary changed outside programming");

  property p_hold;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      (r_reg.state == FPBP_HIGHV && r_next.state == FPBP_HOLD) |=>
      r_reg.high_voltage_enable [*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("High voltage dropped before hold time");

  property p_lock_self;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      (bound_reg != `FPBP_BOUND_OPEN && bound_reg != `FPBP_BOUND_OPEN_ALT
       && !TEST_HV_IN && r_reg.row == `FPBP_BOUND_ADDR) |-> refuse;
  endproperty
  a_lock_self: assert property (p_lock_self)
    else $error("Locked boundary byte left writable");

  property p_erase_clear;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      (r_reg.state == FPBP_HIGHV && r_reg.erase && r_reg.mass && !refuse)
      |=> (bound_reg == `FPBP_BOUND_FACTORY);
  endproperty
  a_erase_clear: assert property (p_erase_clear)
    else $error("Mass erase left boundary byte programmed");

  property p_locked_bound;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      (bound_reg != `FPBP_BOUND_OPEN && bound_reg != `FPBP_BOUND_OPEN_ALT
       && !TEST_HV_IN) |=> $stable(bound_reg);
  endproperty
  a_locked_bound: assert property (p_locked_bound)
    else $error("Locked boundary byte changed");
endmodule // fpbp_top

// >>> testbench/fpbp_cpu.sv
// Software model issuing program and erase sequences
`timescale 1ns/1ns
module fpbp_cpu #(
  parameter int NVH_CYC = 10,
  parameter int RCV_CYC = 4
) (
  // Clock and status from the block
  input wire logic clk_in,
  input wire logic hv_in,
  input wire logic refused_in,
  input wire logic ready_in,
  input wire logic bound_wr_in,
  // Strobes and data to the block
  output logic ctl_wr_out,
  output logic [7:0] ctl_data_out,
  output logic arr_wr_out,
  output logic [15:0] arr_addr_out,
  output logic [7:0] arr_data_out,
  output logic bound_rd_out,
  output logic test_hv_out
);
  // ****************************************
  // Bus cycles, driven on the falling edge
  // ****************************************
  // Quiet bus at time zero
  initial begin
    ctl_wr_out = 1'b0;
    ctl_data_out = 8'h00;
    arr_wr_out = 1'b0;
    arr_addr_out = 16'h0000;
    arr_data_out = 8'h00;
    bound_rd_out = 1'b0;
    test_hv_out = 1'b0;
  end
  // Control byte write; data inverted after release, never stale
  task automatic wr_ctl(input logic [7:0] d);
    @(negedge clk_in);
    ctl_wr_out = 1'b1;
    ctl_data_out = d;
    @(negedge clk_in);
    ctl_wr_out = 1'b0;
    ctl_data_out = ~d;
  endtask
  // Array write; callers pass array addresses only
  task automatic wr_arr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    arr_wr_out = 1'b1;
    arr_addr_out = a;
    arr_data_out = d;
    @(negedge clk_in);
    arr_wr_out = 1'b0;
    arr_addr_out = ~a;
    arr_data_out = ~d;
  endtask
  // Boundary read between arm and high voltage
  task automatic rd_bound();
    @(negedge clk_in);
    bound_rd_out = 1'b1;
    @(negedge clk_in);
    bound_rd_out = 1'b0;
  endtask
  // Test voltage on the interrupt pin
  task automatic set_hv(input logic v);
    @(negedge clk_in);
    test_hv_out = v;
  endtask
  // Full sequence; one byte keeps high-voltage time short
  task automatic seq(input logic [7:0] arm, input logic [15:0] row,
    input logic [7:0] dat, output logic rf, output logic hv,
    output logic bw, output logic rdy);
    int n;
    wr_ctl(arm);
    wr_arr(row, dat);
    rd_bound();
    wr_ctl(arm | 8'h08);
    rf = refused_in;
    hv = hv_in;
    bw = 1'b0;
    if (hv_in === 1'b1) begin
      if (arm[1] === 1'b0) begin
        wr_arr(row, dat);
        bw = bound_wr_in;
      end
      wr_ctl(8'h08);
      repeat (NVH_CYC) @(negedge clk_in);
    end
    wr_ctl(8'h00);
    n = 0;
    while (ready_in !== 1'b1 && n < RCV_CYC + 8) begin
      @(negedge clk_in);
      n++;
    end
    rdy = ready_in;
  endtask
endmodule // fpbp_cpu

// >>> testbench/fpbp_top_tb.sv
// Self-checking bench for the sequencer and block protection
`timescale 1ns/1ns
module fpbp_top_tb;
  // ****************************************
  // Clock, reset, design and software model
  // ****************************************
  localparam int NVH = 10;
  localparam int RCV = 4;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ctl_wr, arr_wr, bound_rd, test_hv;
  logic hv_on, refused, ready, bound_wr;
  logic [7:0] ctl_data, arr_data, ctl_out, bound_out;
  logic [15:0] arr_addr;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  // Half period of 2 ns for 250 MHz
  always #2 clock_in = ~clock_in;
  fpbp_top #(.NVH_CYC(NVH), .RCV_CYC(RCV)) fpbp_top_i (
    .CLOCK_IN(clock_in), .RSTN_IN(rstn_in), .CTL_WR_IN(ctl_wr),
    .CTL_DATA_IN(ctl_data), .ARR_WR_IN(arr_wr), .ARR_ADDR_IN(arr_addr),
    .ARR_DATA_IN(arr_data), .BOUND_RD_IN(bound_rd), .TEST_HV_IN(test_hv),
    .CTL_OUT(ctl_out), .BOUND_OUT(bound_out), .HV_ON_OUT(hv_on),
    .REFUSED_OUT(refused), .READY_OUT(ready), .BOUND_WR_OUT(bound_wr));
  fpbp_cpu #(.NVH_CYC(NVH), .RCV_CYC(RCV)) fpbp_cpu_i (
    .clk_in(clock_in), .hv_in(hv_on), .refused_in(refused),
    .ready_in(ready), .bound_wr_in(bound_wr), .ctl_wr_out(ctl_wr),
    .ctl_data_out(ctl_data), .arr_wr_out(arr_wr),
    .arr_addr_out(arr_addr), .arr_data_out(arr_data),
    .bound_rd_out(bound_rd), .test_hv_out(test_hv));
  // Verdict and end of run
  task automatic stop_test();
    $display("Checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One sequence, then refusal, voltage, ready and boundary
  task automatic op(input logic [7:0] arm, input logic [15:0] row,
    input logic [7:0] dat, input logic rx, input logic [7:0] bx);
    logic rf, hv, bw, rdy;
    fpbp_cpu_i.seq(arm, row, dat, rf, hv, bw, rdy);
    chk("refused", {7'h0, rx}, {7'h0, rf});
    chk("hv_on", {7'h0, ~rx}, {7'h0, hv});
    chk("ready", 8'h01, {7'h0, rdy});
    chk("bound_wr", {7'h0, row == 16'hFF7E && !arm[1] && !rx},
      {7'h0, bw});
    chk("boundary", bx, bound_out);
    chk("control", 8'h00, ctl_out);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge clock_in);
    rstn_in = 1'b1;
    @(negedge clock_in);
    chk("boundary", 8'hFF, bound_out);
    chk("ready", 8'h01, {7'h0, ready});
    fpbp_cpu_i.wr_arr(16'hFF7E, 8'h00);
    chk("boundary", 8'hFF, bound_out);
    fpbp_cpu_i.wr_ctl(8'h05);
    chk("control", 8'h05, ctl_out);
    fpbp_cpu_i.wr_ctl(8'h00);
    chk("control", 8'h00, ctl_out);
    op(8'h01, 16'hFF7E, 8'hFE, 1'b0, 8'hFE);
    op(8'h06, 16'hC000, 8'hFF, 1'b1, 8'hFE);
    op(8'h02, 16'hFF40, 8'hFF, 1'b0, 8'hFF);
    op(8'h01, 16'hFF7E, 8'hFD, 1'b0, 8'hFD);
    op(8'h01, 16'hFF00, 8'h00, 1'b0, 8'hFD);
    op(8'h01, 16'hFF40, 8'h00, 1'b1, 8'hFD);
    op(8'h01, 16'hFF7E, 8'h00, 1'b1, 8'hFD);
    @(negedge clock_in);
    rstn_in = 1'b0;
    repeat (2) @(negedge clock_in);
    rstn_in = 1'b1;
    @(negedge clock_in);
    chk("boundary", 8'hFD, bound_out);
    fpbp_cpu_i.set_hv(1'b1);
    op(8'h01, 16'hFF7E, 8'h00, 1'b0, 8'h00);
    fpbp_cpu_i.set_hv(1'b0);
    op(8'h01, 16'hC000, 8'hFF, 1'b1, 8'h00);
    op(8'h02, 16'hFF40, 8'hFF, 1'b1, 8'h00);
    fpbp_cpu_i.set_hv(1'b1);
    op(8'h06, 16'hC000, 8'hFF, 1'b0, 8'hFF);
    op(8'h01, 16'hFF7E, 8'h00, 1'b0, 8'h00);
    op(8'h02, 16'hFF40, 8'hFF, 1'b0, 8'hFF);
    fpbp_cpu_i.set_hv(1'b0);
    op(8'h06, 16'hC000, 8'hFF, 1'b0, 8'hFF);
    stop_test();
  end
endmodule // fpbp_top_tb
